// File: color_sensor_control_regs.sv
`timescale 1ns/1ps
// Purpose: Control and setting registers of a four-channel light sensor
// Assumes: Single word AHB-Lite transfers, one slave
// Notes:   Reads take one wait state, writes none
module color_sensor_control_regs #(
   parameter int CONV_CYCLES = color_sensor_pkg::CONV_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic                                   clk,
   input  wire logic                                   rstn,
   input  wire logic                                   ce,
   // AHB-Lite slave
   input  wire logic                                   hsel,
   input  wire logic [31:0]                            haddr,
   input  wire logic [1:0]                             htrans,
   input  wire logic                                   hwrite,
   input  wire logic [2:0]                             hsize,
   input  wire logic [31:0]                            hwdata,
   input  wire logic                                   hready,
   output logic                                        hreadyout,
   output logic [31:0]                                 hrdata,
   output logic                                        hresp,
   // Front end
   input  wire logic [color_sensor_pkg::NUM_CH-1:0]
                     [color_sensor_pkg::RES_W-1:0]     adcRaw,
   input  wire logic [color_sensor_pkg::NUM_CH-1:0]
                     [color_sensor_pkg::OFFS_W-1:0]    offsRaw,
   output logic [color_sensor_pkg::NUM_CH-1:0]
                [color_sensor_pkg::GAIN_W-1:0]         gainCount,
   output logic [color_sensor_pkg::NUM_CH-1:0]
                [color_sensor_pkg::INTG_W-1:0]         integSlots,
   output logic                                        extClkSel,
   output logic                                        sleepEn,
   output logic                                        trimEn,
   // Status
   output logic                                        convPending,
   output logic                                        offsPending
);
   import color_sensor_pkg::*;

   localparam int CONV_LAT = CONV_CYCLES + 4;

   meas_if mif ();

   sensor_measure_engine #(
      .CONV_CYCLES (CONV_CYCLES)
   ) uEngine (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .mp   (mif.engine)
   );

   logic                           wrPend_q, wrPend_d;
   logic                           rdPend_q, rdPend_d;
   logic [7:0]                     idx_q, idx_d;
   logic                           ready_q, ready_d;
   logic [31:0]                    rdata_q, rdata_d;
   logic [1:0]                     ctrl_q, ctrl_d;
   logic [2:0]                     cfg_q, cfg_d;
   logic [NUM_CH-1:0][GAIN_W-1:0]  gain_q, gain_d;
   logic [NUM_CH-1:0][INTG_W-1:0]  intg_q, intg_d;
   logic                           addrPhase;
   logic [7:0]                     wrByte;
   logic [7:0]                     rdByte;

   assign addrPhase = hsel && htrans[1] && hready;
   assign wrByte    = hwdata[7:0];

   // Bus phase tracking and read data
   always_comb begin
      wrPend_d = addrPhase && hwrite;
      rdPend_d = addrPhase && !hwrite;
      idx_d    = addrPhase ? haddr[9:2] : idx_q;
      ready_d  = !(addrPhase && !hwrite);
      rdata_d  = rdPend_q ? {24'h000000, rdByte} : rdata_q;
   end

   // Read multiplexer, unmapped reads return zero
   always_comb begin
      rdByte = 8'h00;
      if (idx_q == IDX_CONTROL) begin
         rdByte = {6'h00, ctrl_q};
      end else if (idx_q == IDX_CONFIG) begin
         rdByte = {5'h00, cfg_q};
      end
      for (int c = 0; c < NUM_CH; c++) begin
         if (idx_q == IDX_GAIN_BASE + 8'(c)) begin
            rdByte = {4'h0, gain_q[c]};
         end
         if (idx_q == IDX_INTG_BASE + 8'(2 * c)) begin
            rdByte = intg_q[c][7:0];
         end
         if (idx_q == IDX_INTG_BASE + 8'(2 * c + 1)) begin
            rdByte = {4'h0, intg_q[c][INTG_W-1:8]};
         end
         if (idx_q == IDX_DATA_BASE + 8'(2 * c)) begin
            rdByte = mif.result[c][7:0];
         end
         if (idx_q == IDX_DATA_BASE + 8'(2 * c + 1)) begin
            rdByte = {6'h00, mif.result[c][RES_W-1:8]};
         end
         if (idx_q == IDX_OFFS_BASE + 8'(c)) begin
            rdByte = mif.offsResult[c];
         end
      end
   end

   // Register updates; hardware clear loses to a software set
   always_comb begin
      ctrl_d = ctrl_q;
      cfg_d  = cfg_q;
      gain_d = gain_q;
      intg_d = intg_q;
      if (mif.convDone) begin
         ctrl_d[CTRL_CONV_BIT] = 1'b0;
      end
      if (mif.offsDone) begin
         ctrl_d[CTRL_OFFS_BIT] = 1'b0;
      end
      if (wrPend_q) begin
         if (idx_q == IDX_CONTROL) begin
            ctrl_d = ctrl_d | wrByte[1:0];
         end
         if (idx_q == IDX_CONFIG) begin
            cfg_d = wrByte[2:0];
         end
         for (int c = 0; c < NUM_CH; c++) begin
            if (idx_q == IDX_GAIN_BASE + 8'(c)) begin
               gain_d[c] = wrByte[GAIN_W-1:0];
            end
            if (idx_q == IDX_INTG_BASE + 8'(2 * c)) begin
               intg_d[c][7:0] = wrByte;
            end
            if (idx_q == IDX_INTG_BASE + 8'(2 * c + 1)) begin
               intg_d[c][INTG_W-1:8] = wrByte[3:0];
            end
         end
      end
      if (!cfg_d[CFG_EXTERNAL_CLOCK_SELECT_BIT]) begin
         cfg_d[CFG_SLEEP_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         idx_q    <= 8'h00;
         ready_q  <= 1'b1;
         rdata_q  <= 32'h00000000;
         ctrl_q   <= CTRL_RESET;
         cfg_q    <= CFG_RESET;
         gain_q   <= {NUM_CH{GAIN_RESET}};
         intg_q   <= {NUM_CH{INTG_RESET}};
      end else if (ce) begin
         wrPend_q <= wrPend_d;
         rdPend_q <= rdPend_d;
         idx_q    <= idx_d;
         ready_q  <= ready_d;
         rdata_q  <= rdata_d;
         ctrl_q   <= ctrl_d;
         cfg_q    <= cfg_d;
         gain_q   <= gain_d;
         intg_q   <= intg_d;
      end
   end

   assign mif.convReq = ctrl_q[CTRL_CONV_BIT];
   assign mif.offsReq = ctrl_q[CTRL_OFFS_BIT];
   assign mif.trimEn  = cfg_q[CFG_TRIM_BIT];
   assign mif.rawData = adcRaw;
   assign mif.rawOffs = offsRaw;

   assign hreadyout   = ready_q;
   assign hrdata      = rdata_q;
   assign hresp       = 1'b0;
   assign gainCount   = gain_q;
   assign integSlots  = intg_q;
   assign extClkSel   = cfg_q[CFG_EXTERNAL_CLOCK_SELECT_BIT];
   assign sleepEn     = cfg_q[CFG_SLEEP_BIT];
   assign trimEn      = cfg_q[CFG_TRIM_BIT];
   assign convPending = ctrl_q[CTRL_CONV_BIT];
   assign offsPending = ctrl_q[CTRL_OFFS_BIT];

   AST_CONV_CLEARS: assert property (
      @(posedge clk) disable iff (!rstn)
      $rose(convPending) |-> ##[1:CONV_LAT] !convPending)
      else $error("Conversion bit did not self clear");
   AST_OFFS_CLEARS: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && !convPending && $rose(offsPending)) |->
      ##[1:CONV_LAT] !offsPending)
      else $error("Offset bit did not self clear");
   AST_EXTERNAL_CLOCK_SELECT_WRITE: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && wrPend_q && idx_q == IDX_CONFIG) |=>
      (extClkSel == $past(hwdata[CFG_EXTERNAL_CLOCK_SELECT_BIT])))
      else $error("External clock select not written");
   AST_SLEEP_EXT_ONLY: assert property (
      @(posedge clk) disable iff (!rstn)
      sleepEn |-> extClkSel)
      else $error("Sleep set without external clock");
   AST_GAIN_WRITE: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && wrPend_q && idx_q == IDX_GAIN_BASE) |=>
      (gainCount[0] == $past(hwdata[3:0])))
      else $error("Red gain count not written");
   AST_INTG_HI_WRITE: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && wrPend_q && idx_q == IDX_INTG_BASE + 8'h01) |=>
      (integSlots[0][11:8] == $past(hwdata[3:0])))
      else $error("Integration high nibble not written");
   AST_DATA_HI_READ: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && rdPend_q && idx_q == IDX_DATA_BASE + 8'h01) |=>
      (hreadyout && hrdata[31:2] == 30'h0
       && hrdata[1:0] == $past(mif.result[0][9:8])))
      else $error("Result high byte read wrong");

   AST_CONV_SET: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && wrPend_q && idx_q == IDX_CONTROL && wrByte[CTRL_CONV_BIT])
      |=> convPending)
      else $error("Conversion bit not set by write");
   AST_OFFS_SET: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && wrPend_q && idx_q == IDX_CONTROL && wrByte[CTRL_OFFS_BIT])
      |=> offsPending)
      else $error("Offset bit not set by write");
   AST_CONV_HOLD: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && convPending && !mif.convDone) |=> convPending)
      else $error("Conversion bit cleared before done");
   AST_OFFS_HOLD: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && offsPending && !mif.offsDone) |=> offsPending)
      else $error("Offset bit cleared before done");
   AST_TRIM_WRITE: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && wrPend_q && idx_q == IDX_CONFIG) |=>
      (trimEn == $past(wrByte[CFG_TRIM_BIT])))
      else $error("Trim offset bit not written");
   AST_SLEEP_WRITE: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && wrPend_q && idx_q == IDX_CONFIG) |=>
      (sleepEn == $past(wrByte[CFG_SLEEP_BIT] && wrByte[CFG_EXTERNAL_CLOCK_SELECT_BIT])))
      else $error("Sleep bit not written or not cleared");
   AST_CFG_KEEP: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && !(wrPend_q && idx_q == IDX_CONFIG)) |=>
      $stable({extClkSel, sleepEn, trimEn}))
      else $error("Configuration changed without a write");
   AST_WRITE_NO_WAIT: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && addrPhase && hwrite) |=> hreadyout)
      else $error("Write data phase was stalled");
   AST_READ_WAIT: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && addrPhase && !hwrite) |=> !hreadyout)
      else $error("Read data phase had no wait state");
   AST_READ_DONE: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && rdPend_q) |=> hreadyout)
      else $error("Read wait state lasted too long");
   AST_BUS_OKAY: assert property (
      @(posedge clk) disable iff (!rstn)
      !hresp && hrdata[31:8] == 24'h000000)
      else $error("Bus response or read data upper bits wrong");
   AST_CE_FREEZE: assert property (
      @(posedge clk) disable iff (!rstn)
      !ce |=> ($stable(ctrl_q) && $stable(cfg_q) && $stable(gain_q)
               && $stable(intg_q) && $stable(ready_q)))
      else $error("State moved while clock enable was low");

   // Per-channel register checks
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gChk
         AST_GAIN_CH: assert property (
            @(posedge clk) disable iff (!rstn)
            (ce && wrPend_q && idx_q == IDX_GAIN_BASE + 8'(g)) |=>
            (gainCount[g] == $past(hwdata[GAIN_W-1:0])))
            else $error("Gain count not written");
         AST_GAIN_KEEP: assert property (
            @(posedge clk) disable iff (!rstn)
            (ce && !(wrPend_q && idx_q == IDX_GAIN_BASE + 8'(g))) |=>
            $stable(gainCount[g]))
            else $error("Gain count changed without a write");
         AST_INTG_LO_CH: assert property (
            @(posedge clk) disable iff (!rstn)
            (ce && wrPend_q && idx_q == IDX_INTG_BASE + 8'(2 * g)) |=>
            (integSlots[g][7:0] == $past(hwdata[7:0])))
            else $error("Integration low byte not written");
         AST_INTG_HI_CH: assert property (
            @(posedge clk) disable iff (!rstn)
            (ce && wrPend_q && idx_q == IDX_INTG_BASE + 8'(2 * g + 1)) |=>
            (integSlots[g][INTG_W-1:8] == $past(hwdata[3:0])))
            else $error("Integration high nibble not written");
         AST_INTG_KEEP: assert property (
            @(posedge clk) disable iff (!rstn)
            (ce && !(wrPend_q && (idx_q == IDX_INTG_BASE + 8'(2 * g)
               || idx_q == IDX_INTG_BASE + 8'(2 * g + 1)))) |=>
            $stable(integSlots[g]))
            else $error("Integration count changed without a write");
         AST_DATA_LO_CH: assert property (
            @(posedge clk) disable iff (!rstn)
            (ce && rdPend_q && idx_q == IDX_DATA_BASE + 8'(2 * g)) |=>
            (hrdata == {24'h000000, $past(mif.result[g][7:0])}))
            else $error("Result low byte read wrong");
         AST_DATA_HI_CH: assert property (
            @(posedge clk) disable iff (!rstn)
            (ce && rdPend_q && idx_q == IDX_DATA_BASE + 8'(2 * g + 1)) |=>
            (hrdata == {30'h0, $past(mif.result[g][RES_W-1:8])}))
            else $error("Result high bits read wrong");
         AST_OFFS_CH: assert property (
            @(posedge clk) disable iff (!rstn)
            (ce && rdPend_q && idx_q == IDX_OFFS_BASE + 8'(g)) |=>
            (hrdata == {24'h000000, $past(mif.offsResult[g])}))
            else $error("Offset result read wrong");
      end
   endgenerate
endmodule

// File: color_sensor_pkg.sv
// Purpose: Shared constants and types for the colour sensor register bank
// Assumes: Byte address on the bus is four times the register index
// Notes:   Functional notes below
//
// Functional notes
// - Conversion bit starts conversion, self clears
// - Offset bit starts offset measure, self clears
// - Config bit 2 selects external clock
// - Sleep holds only while external clock selected
// - Config bit 0 applies offsets to conversions
// - Four-bit gain count per channel, low nibble
// - Twelve-bit integration count in two bytes
// - Ten-bit result, low byte plus two bits
// - Offset byte is sign plus magnitude
package color_sensor_pkg;
   localparam int NUM_CH  = 4;
   localparam int GAIN_W  = 4;
   localparam int INTG_W  = 12;
   localparam int RES_W   = 10;
   localparam int OFFS_W  = 8;
   localparam int CONV_CYCLES_DEF = 16;

   // Register indices
   localparam logic [7:0] IDX_CONTROL   = 8'h00;
   localparam logic [7:0] IDX_CONFIG    = 8'h01;
   localparam logic [7:0] IDX_GAIN_BASE = 8'h06;
   localparam logic [7:0] IDX_INTG_BASE = 8'h0A;
   localparam logic [7:0] IDX_DATA_BASE = 8'h40;
   localparam logic [7:0] IDX_OFFS_BASE = 8'h48;

   // Bit positions
   localparam int CTRL_CONV_BIT  = 0;
   localparam int CTRL_OFFS_BIT  = 1;
   localparam int CFG_TRIM_BIT   = 0;
   localparam int CFG_SLEEP_BIT  = 1;
   localparam int CFG_EXTERNAL_CLOCK_SELECT_BIT = 2;
   localparam int OFFS_SIGN_BIT  = 7;

   // Reset values
   localparam logic [1:0]        CTRL_RESET = 2'h0;
   localparam logic [2:0]        CFG_RESET  = 3'h0;
   localparam logic [GAIN_W-1:0] GAIN_RESET = 4'hF;
   localparam logic [INTG_W-1:0] INTG_RESET = 12'h000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_OFFS = 2'b10
   } meas_state_t;
endpackage

// File: meas_if.sv
`timescale 1ns/1ps
// Purpose: Carrier between register bank and measurement engine
// Assumes: Single clock domain
// Notes:   Results are held by the engine
interface meas_if;
   import color_sensor_pkg::*;
   logic                             convReq;
   logic                             offsReq;
   logic                             trimEn;
   logic [NUM_CH-1:0][RES_W-1:0]     rawData;
   logic [NUM_CH-1:0][OFFS_W-1:0]    rawOffs;
   logic                             convDone;
   logic                             offsDone;
   logic [NUM_CH-1:0][RES_W-1:0]     result;
   logic [NUM_CH-1:0][OFFS_W-1:0]    offsResult;

   modport regs (output convReq, offsReq, trimEn, rawData, rawOffs,
                 input convDone, offsDone, result, offsResult);
   modport engine (input convReq, offsReq, trimEn, rawData, rawOffs,
                   output convDone, offsDone, result, offsResult);
endinterface

// File: sensor_front_model.sv
// Purpose: Front-end model presenting raw channel values
// Assumes: Bench sets values between measurements
// Notes:   Values are registered on each rising edge
`timescale 1ns/1ps
module sensor_front_model (
   // Clock
   input  wire logic clk,
   // Setpoints from bench
   input  wire logic [color_sensor_pkg::NUM_CH-1:0]
                     [color_sensor_pkg::RES_W-1:0]  setAdc,
   input  wire logic [color_sensor_pkg::NUM_CH-1:0]
                     [color_sensor_pkg::OFFS_W-1:0] setOffs,
   // Raw values to the device
   output logic [color_sensor_pkg::NUM_CH-1:0]
                [color_sensor_pkg::RES_W-1:0]       adcRaw,
   output logic [color_sensor_pkg::NUM_CH-1:0]
                [color_sensor_pkg::OFFS_W-1:0]      offsRaw
);
   import color_sensor_pkg::*;
   always_ff @(posedge clk) begin
      adcRaw  <= setAdc;
      offsRaw <= setOffs;
   end
endmodule

// File: sensor_measure_engine.sv
`timescale 1ns/1ps
// Purpose: Conversion and offset measurement sequencer
// Assumes: Front-end values are stable at the end of a measurement
// Notes:   Requests are taken only when idle and not just done
module sensor_measure_engine #(
   parameter int CONV_CYCLES = color_sensor_pkg::CONV_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic ce,
   // Register side
   meas_if.engine    mp
);
   import color_sensor_pkg::*;

   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(CONV_CYCLES - 1);

   meas_state_t                    state_q, state_d;
   logic [CW-1:0]                  cnt_q, cnt_d;
   logic                           convDone_q, convDone_d;
   logic                           offsDone_q, offsDone_d;
   logic [NUM_CH-1:0][RES_W-1:0]   res_q, res_d;
   logic [NUM_CH-1:0][OFFS_W-1:0]  offs_q, offs_d;
   logic [NUM_CH-1:0][RES_W-1:0]   trimmed;

   // Offset correction per channel
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : gTrim
         logic [RES_W:0] mag;
         logic [RES_W:0] sum;
         assign mag = {4'h0, offs_q[ch][OFFS_SIGN_BIT-1:0]};
         assign sum = {1'b0, mp.rawData[ch]} + mag;
         always_comb begin
            if (!mp.trimEn) begin
               trimmed[ch] = mp.rawData[ch];
            end else if (offs_q[ch][OFFS_SIGN_BIT]) begin
               trimmed[ch] = sum[RES_W] ? {RES_W{1'b1}} : sum[RES_W-1:0];
            end else if ({1'b0, mp.rawData[ch]} < mag) begin
               trimmed[ch] = '0;
            end else begin
               trimmed[ch] = mp.rawData[ch] - mag[RES_W-1:0];
            end
         end
      end
   endgenerate

   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      convDone_d = 1'b0;
      offsDone_d = 1'b0;
      res_d      = res_q;
      offs_d     = offs_q;
      case (state_q)
         ST_IDLE: begin
            if (!convDone_q && !offsDone_q) begin
               if (mp.convReq) begin
                  state_d = ST_CONV;
                  cnt_d   = CNT_LOAD;
               end else if (mp.offsReq) begin
                  state_d = ST_OFFS;
                  cnt_d   = CNT_LOAD;
               end
            end
         end
         ST_CONV: begin
            if (cnt_q == '0) begin
               res_d      = trimmed;
               convDone_d = 1'b1;
               state_d    = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_OFFS: begin
            if (cnt_q == '0) begin
               offs_d     = mp.rawOffs;
               offsDone_d = 1'b1;
               state_d    = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q    <= ST_IDLE;
         cnt_q      <= '0;
         convDone_q <= 1'b0;
         offsDone_q <= 1'b0;
         res_q      <= '0;
         offs_q     <= '0;
      end else if (ce) begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         convDone_q <= convDone_d;
         offsDone_q <= offsDone_d;
         res_q      <= res_d;
         offs_q     <= offs_d;
      end
   end

   assign mp.convDone   = convDone_q;
   assign mp.offsDone   = offsDone_q;
   assign mp.result     = res_q;
   assign mp.offsResult = offs_q;

   AST_RESULT_RAW: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && state_q == ST_CONV && cnt_q == '0 && !mp.trimEn) |=>
      (res_q[0] == $past(mp.rawData[0])))
      else $error("Untrimmed result differs from raw value");
   AST_TRIM_POS: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && state_q == ST_CONV && cnt_q == '0 && mp.trimEn
       && !offs_q[0][OFFS_SIGN_BIT]) |=>
      (res_q[0] <= $past(mp.rawData[0])))
      else $error("Positive offset did not lower result");
   AST_OFFS_CAPTURE: assert property (
      @(posedge clk) disable iff (!rstn)
      (ce && state_q == ST_OFFS && cnt_q == '0) |=>
      (offsDone_q && offs_q[1] == $past(mp.rawOffs[1])))
      else $error("Offset result not captured");
endmodule

// File: tb_color_sensor_control_regs.sv
// Purpose: Self-checking bench for the sensor register bank
// Assumes: Short conversion time, bus ready fed back
// Notes:   Expectations come from an integer model
`timescale 1ns/1ps
module tb_color_sensor_control_regs;
   import color_sensor_pkg::*;
   logic                             clk = 1'b0;
   logic                             rstn = 1'b0;
   logic                             ce = 1'b1;
   logic                             hsel = 1'b0;
   logic                             hwrite = 1'b0;
   logic [1:0]                       htrans = 2'b00;
   logic [2:0]                       hsize = 3'h2;
   logic [31:0]                      haddr = 32'h0;
   logic [31:0]                      hwdata = 32'h0;
   logic                             hreadyout, hresp, extClkSel;
   logic                             sleepEn, trimEn, convPending;
   logic                             offsPending;
   logic [31:0]                      hrdata, rdv, v, seed;
   logic [NUM_CH-1:0][RES_W-1:0]     setAdc = '0;
   logic [NUM_CH-1:0][RES_W-1:0]     adcRaw;
   logic [NUM_CH-1:0][OFFS_W-1:0]    setOffs = '0;
   logic [NUM_CH-1:0][OFFS_W-1:0]    offsRaw;
   logic [NUM_CH-1:0][GAIN_W-1:0]    gainCount;
   logic [NUM_CH-1:0][INTG_W-1:0]    integSlots;
   logic [2:0]                       cfgTab [5];
   int                               gainM [4];
   int                               intgM [4];
   int                               c, t, e, n_mismatch, checks, cyc;
   wire                              hready = hreadyout;

   always #5 clk = ~clk;

   color_sensor_control_regs #(.CONV_CYCLES(2)) dut_u (
      .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .adcRaw(adcRaw), .offsRaw(offsRaw),
      .gainCount(gainCount), .integSlots(integSlots),
      .extClkSel(extClkSel), .sleepEn(sleepEn), .trimEn(trimEn),
      .convPending(convPending), .offsPending(offsPending));

   sensor_front_model front_u (.clk(clk), .setAdc(setAdc),
      .setOffs(setOffs), .adcRaw(adcRaw), .offsRaw(offsRaw));

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Conversion with optional offset trim, saturated
   function automatic int trimmed(int a, int o, bit tr);
      int r;
      r = a;
      if (tr) begin
         r = o[7] ? a + (o & 127) : a - (o & 127);
      end
      if (r < 0) r = 0;
      if (r > 1023) r = 1023;
      return r;
   endfunction

   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // One single AHB-Lite transfer
   task automatic xfer(logic w, logic [7:0] idx, logic [31:0] wd);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {22'h0, idx, 2'b00};
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(logic [7:0] idx, logic [31:0] d);
      xfer(1'b1, idx, d);
   endtask

   task automatic rdr(logic [7:0] idx);
      xfer(1'b0, idx, 32'h0);
   endtask

   task automatic measure(int b);
      wr(IDX_CONTROL, 32'(1 << b));
      #1;
      check("pending", {31'h0, b == 0 ? convPending : offsPending}, 1);
      for (int k = 0; k < 40; k++) begin
         rdr(IDX_CONTROL);
         if (rdv[1:0] === 2'b00) break;
      end
      check("ctrl clear", rdv, 32'h0);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         stop_test();
      end
   end

   initial begin
      seed = 32'hF0D9;
      cfgTab = '{3'h2, 3'h6, 3'h5, 3'h3, 3'h0};
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      for (c = 0; c < 4; c++) begin
         rdr(8'(IDX_GAIN_BASE + c));
         check("gain rst", rdv, 32'hF);
         rdr(8'(IDX_INTG_BASE + 2 * c));
         check("intg rst", rdv, 32'h0);
      end
      rdr(IDX_CONFIG);
      check("cfg rst", rdv, 32'h0);
      for (c = 0; c < 4; c++) begin
         v = rnd();
         wr(8'(IDX_GAIN_BASE + c), v);
         gainM[c] = int'(v[3:0]);
         v = rnd();
         wr(8'(IDX_INTG_BASE + 2 * c), v);
         wr(8'(IDX_INTG_BASE + 2 * c + 1), v >> 8);
         intgM[c] = int'(v[11:0]);
      end
      for (c = 0; c < 4; c++) begin
         rdr(8'(IDX_GAIN_BASE + c));
         check("gain", rdv, 32'(gainM[c]));
         check("gain pin", 32'(gainCount[c]), 32'(gainM[c]));
         rdr(8'(IDX_INTG_BASE + 2 * c));
         check("intg lo", rdv, 32'(intgM[c] & 255));
         rdr(8'(IDX_INTG_BASE + 2 * c + 1));
         check("intg hi", rdv, 32'(intgM[c] >> 8));
         check("intg pin", 32'(integSlots[c]), 32'(intgM[c]));
      end
      ce <= 1'b0;
      wr(IDX_GAIN_BASE, 32'(gainM[0] ^ 15));
      ce <= 1'b1;
      rdr(IDX_GAIN_BASE);
      check("gain frozen", rdv, 32'(gainM[0]));
      for (c = 0; c < 5; c++) begin
         e = cfgTab[c] & (cfgTab[c][2] ? 7 : 5);
         wr(IDX_CONFIG, 32'(cfgTab[c]));
         rdr(IDX_CONFIG);
         check("cfg", rdv, 32'(e));
         check("cfg pins", {29'h0, extClkSel, sleepEn, trimEn}, 32'(e));
      end
      wr(8'h20, 32'hFF);
      rdr(8'h20);
      check("unmapped", rdv, 32'h0);
      for (c = 0; c < 4; c++) setOffs[c] <= 8'(rnd());
      measure(1);
      for (c = 0; c < 4; c++) begin
         rdr(8'(IDX_OFFS_BASE + c));
         check("offset", rdv, 32'(setOffs[c]));
      end
      for (t = 0; t < 2; t++) begin
         wr(IDX_CONFIG, 32'(t));
         for (c = 0; c < 4; c++) setAdc[c] <= 10'(rnd());
         measure(0);
         wr(IDX_DATA_BASE, 32'hFF);
         for (c = 0; c < 4; c++) begin
            e = trimmed(int'(setAdc[c]), int'(setOffs[c]), t[0]);
            rdr(8'(IDX_DATA_BASE + 2 * c));
            check("data lo", rdv, 32'(e & 255));
            rdr(8'(IDX_DATA_BASE + 2 * c + 1));
            check("data hi", rdv, 32'(e >> 8));
         end
      end
      stop_test();
   end
endmodule
